/* common/dpr_pkg.sv */
// Purpose: Shared constants for the dual-ported staging RAM.
// Assumes: One system clock; 16-bit byte addresses on both ports.
// Notes:   The region sits at the top of the Y data space.
package dpr_pkg;
  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 16;
  localparam int          RAM_BYTES   = 2048;
  localparam int          RAM_WORDS   = RAM_BYTES / 2;
  localparam int          IDX_W       = $clog2(RAM_WORDS);
  localparam logic [15:0] REGION_BASE = 16'h7800;
  localparam logic [15:0] REGION_LAST = 16'h7fff;
  localparam int          BYTE_SEL_POS = 0;
  localparam logic [15:0] RD_RESET     = 16'h0000;
endpackage

/* common/dpr_port_if.sv */
// Purpose: One access port of the dual-ported RAM.
// Assumes: Requests are taken on every clock edge where en is high.
// Notes:   Used between the top module and its storage core.
interface dpr_port_if;
  logic        en;
  logic        we;
  logic [9:0]  idx;
  logic [1:0]  wstrb;
  logic [15:0] wdata;
  logic [15:0] rword;
  modport host (output en, output we, output idx, output wstrb, output wdata, input rword);
  modport core (input en, input we, input idx, input wstrb, input wdata, output rword);
endinterface

/* hdl/dpr_core.sv */
// Purpose: Word storage with two ports and per-byte write strobes.
// Assumes: Both ports on one clock; indexes already decoded.
// Notes:   Port a is the CPU port and wins a same-word write clash.
module dpr_core #(
  parameter int WORDS = 1024
) (
  input  wire logic clk,
  dpr_port_if.core  pa,
  dpr_port_if.core  pb
);
  import dpr_pkg::*;

  if (WORDS != 1024) begin : g_words_check
    $error("dpr_core serves only the 1024-word region");
  end

  logic [15:0] mem [WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // Writes: DMA lanes first, CPU lanes after, so the CPU value is kept.
  always_ff @(posedge clk) begin
    for (int b = 0; b < 2; b++) begin
      if (pb.en && pb.we && pb.wstrb[b]) begin
        mem[pb.idx][b*8 +: 8] <= pb.wdata[b*8 +: 8];
      end
      if (pa.en && pa.we && pa.wstrb[b]) begin
        mem[pa.idx][b*8 +: 8] <= pa.wdata[b*8 +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reads return the stored word; neither port waits on the other.
  always_ff @(posedge clk) begin
    if (pa.en) begin
      pa.rword <= mem[pa.idx];
    end
    if (pb.en) begin
      pb.rword <= mem[pb.idx];
    end
  end
endmodule

/* hdl/dpr_ram.sv */
// Notes on behaviour
// - A 2 KB dual-ported region sits at the top end of Y data space.
// - CPU and DMA ports are independent and may both access in one cycle.
// - DMA accesses never stall or take cycles from the CPU port.
// - Same-location writes in one cycle keep the CPU port data.
// - Without DMA the CPU uses it as plain read/write storage.
// - Shared word decode, separate byte strobes; byte writes touch one half.
// - 16-bit byte addresses, low byte even, byte read picks by bit 0.
//
// Purpose: Dual-ported staging RAM shared by the CPU and the DMA engine.
// Assumes: Synchronous active-high reset; one read cycle of latency.
// Notes:   Accesses outside the region are ignored and read as zero.
module dpr_ram (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 cpu_en,
  input  wire logic                 cpu_we,
  input  wire logic                 cpu_byte,
  input  wire logic [dpr_pkg::ADDR_W-1:0] cpu_addr,
  input  wire logic [dpr_pkg::DATA_W-1:0] cpu_wdata,
  output logic      [dpr_pkg::DATA_W-1:0] cpu_rdata,
  output logic                      cpu_rvalid,
  input  wire logic                 dma_en,
  input  wire logic                 dma_we,
  input  wire logic                 dma_byte,
  input  wire logic [dpr_pkg::ADDR_W-1:0] dma_addr,
  input  wire logic [dpr_pkg::DATA_W-1:0] dma_wdata,
  output logic      [dpr_pkg::DATA_W-1:0] dma_rdata,
  output logic                      dma_rvalid
);
  import dpr_pkg::*;

  dpr_port_if cpu_p ();
  dpr_port_if dma_p ();

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers, shared by both ports.
  function automatic logic in_region(input logic [15:0] a);
    return (a >= REGION_BASE) && (a <= REGION_LAST);
  endfunction

  function automatic logic [1:0] lanes(input logic bytewise, input logic [15:0] a);
    if (!bytewise) begin
      return 2'h3;
    end
    return a[BYTE_SEL_POS] ? 2'h2 : 2'h1;
  endfunction

  function automatic logic [15:0] place(input logic bytewise, input logic [15:0] d);
    return bytewise ? {d[7:0], d[7:0]} : d;
  endfunction

  function automatic logic [15:0] pick(input logic bytewise, input logic hi,
                                       input logic [15:0] w);
    if (!bytewise) begin
      return w;
    end
    return hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction

  logic cpu_hit;
  logic dma_hit;
  assign cpu_hit = cpu_en && in_region(cpu_addr);
  assign dma_hit = dma_en && in_region(dma_addr);

  // Word alignment ignores bit 0; a misaligned word access uses its word.
  assign cpu_p.en    = cpu_hit;
  assign cpu_p.we    = cpu_we;
  assign cpu_p.idx   = cpu_addr[IDX_W:1];
  assign cpu_p.wstrb = lanes(cpu_byte, cpu_addr);
  assign cpu_p.wdata = place(cpu_byte, cpu_wdata);
  assign dma_p.en    = dma_hit;
  assign dma_p.we    = dma_we;
  assign dma_p.idx   = dma_addr[IDX_W:1];
  assign dma_p.wstrb = lanes(dma_byte, dma_addr);
  assign dma_p.wdata = place(dma_byte, dma_wdata);

  dpr_core #(.WORDS(RAM_WORDS)) u_core (
    .clk (clk),
    .pa  (cpu_p.core),
    .pb  (dma_p.core)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read tags, held one cycle to steer the returned word.
  logic cpu_rd_reg, cpu_hitr_reg, cpu_bt_reg, cpu_hi_reg;
  logic dma_rd_reg, dma_hitr_reg, dma_bt_reg, dma_hi_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_rd_reg   <= 1'b0;
      cpu_hitr_reg <= 1'b0;
      cpu_bt_reg   <= 1'b0;
      cpu_hi_reg   <= 1'b0;
    end else begin
      cpu_rd_reg   <= cpu_en && !cpu_we;
      cpu_hitr_reg <= cpu_hit;
      cpu_bt_reg   <= cpu_byte;
      cpu_hi_reg   <= cpu_addr[BYTE_SEL_POS];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dma_rd_reg   <= 1'b0;
      dma_hitr_reg <= 1'b0;
      dma_bt_reg   <= 1'b0;
      dma_hi_reg   <= 1'b0;
    end else begin
      dma_rd_reg   <= dma_en && !dma_we;
      dma_hitr_reg <= dma_hit;
      dma_bt_reg   <= dma_byte;
      dma_hi_reg   <= dma_addr[BYTE_SEL_POS];
    end
  end

  assign cpu_rvalid = cpu_rd_reg;
  assign dma_rvalid = dma_rd_reg;

  logic [15:0] cpu_word;
  logic [15:0] dma_word;
  assign cpu_word = cpu_hitr_reg ? pick(cpu_bt_reg, cpu_hi_reg, cpu_p.rword) : RD_RESET;
  assign dma_word = dma_hitr_reg ? pick(dma_bt_reg, dma_hi_reg, dma_p.rword) : RD_RESET;
  // Steering sits after the core's read flops so the data stands with rvalid.
  assign cpu_rdata = cpu_word;
  assign dma_rdata = dma_word;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  a_cpu_rd_lat: assert property (@(posedge clk) disable iff (rst)
    cpu_en && !cpu_we |=> cpu_rvalid)
    else $error("cpu read valid not one cycle later");

  a_dma_no_stall: assert property (@(posedge clk) disable iff (rst)
    cpu_en && dma_en && !cpu_we |=> cpu_rvalid)
    else $error("cpu read delayed by dma");

  a_rd_quiet: assert property (@(posedge clk) disable iff (rst)
    !(cpu_en && !cpu_we) |=> !cpu_rvalid)
    else $error("cpu read valid without a read");

  a_dma_lat: assert property (@(posedge clk) disable iff (rst)
    dma_en && !dma_we |=> dma_rvalid)
    else $error("dma read valid not one cycle later");

  a_dma_quiet: assert property (@(posedge clk) disable iff (rst)
    !(dma_en && !dma_we) |=> !dma_rvalid)
    else $error("dma read valid without a read");

  // Store checks follow a write through one quiet cycle to a read of that word.
  a_cpu_wins: assert property (@(posedge clk) disable iff (rst)
    cpu_hit && dma_hit && cpu_we && dma_we && !cpu_byte && !dma_byte
    && cpu_addr == dma_addr
    ##1 !(cpu_en && cpu_we) && !(dma_en && dma_we)
    ##1 cpu_hit && !cpu_we && !cpu_byte && cpu_addr == $past(cpu_addr, 2)
    |=> cpu_word == $past(cpu_wdata, 3))
    else $error("cpu write lost on clash");

  a_dma_sees_cpu: assert property (@(posedge clk) disable iff (rst)
    cpu_hit && cpu_we && !cpu_byte && !(dma_en && dma_we && dma_p.idx == cpu_p.idx)
    ##1 !(cpu_en && cpu_we) && !(dma_en && dma_we)
    ##1 dma_hit && !dma_we && !dma_byte && dma_addr == $past(cpu_addr, 2)
    |=> dma_word == $past(cpu_wdata, 3))
    else $error("dma read misses cpu write");

  a_cpu_sees_dma: assert property (@(posedge clk) disable iff (rst)
    dma_hit && dma_we && !dma_byte && !(cpu_en && cpu_we && cpu_p.idx == dma_p.idx)
    ##1 !(cpu_en && cpu_we) && !(dma_en && dma_we)
    ##1 cpu_hit && !cpu_we && !cpu_byte && cpu_addr == $past(dma_addr, 2)
    |=> cpu_word == $past(dma_wdata, 3))
    else $error("cpu read misses dma write");

  a_same_read: assert property (@(posedge clk) disable iff (rst)
    cpu_hit && dma_hit && !cpu_we && !dma_we && !cpu_byte && !dma_byte
    && cpu_addr == dma_addr |=> cpu_word == dma_word)
    else $error("same-word reads differ");

  a_word_lanes: assert property (@(posedge clk) disable iff (rst)
    cpu_hit && cpu_we && !cpu_byte |-> cpu_p.wstrb == 2'h3 && cpu_p.wdata == cpu_wdata)
    else $error("word write not on both lanes");

  a_byte_lane: assert property (@(posedge clk) disable iff (rst)
    cpu_hit && cpu_we && cpu_byte |-> $onehot(cpu_p.wstrb) && cpu_p.wstrb[1] == cpu_addr[0])
    else $error("cpu byte write on wrong lane");

  a_dma_byte_lane: assert property (@(posedge clk) disable iff (rst)
    dma_hit && dma_we && dma_byte |-> $onehot(dma_p.wstrb) && dma_p.wstrb[1] == dma_addr[0])
    else $error("dma byte write on wrong lane");

  a_byte_copy: assert property (@(posedge clk) disable iff (rst)
    cpu_hit && cpu_we && cpu_byte |-> cpu_p.wdata == {2{cpu_wdata[7:0]}})
    else $error("cpu byte data not on both halves");

  a_dma_byte_copy: assert property (@(posedge clk) disable iff (rst)
    dma_hit && dma_we && dma_byte |-> dma_p.wdata == {2{dma_wdata[7:0]}})
    else $error("dma byte data not on both halves");

  a_cpu_index: assert property (@(posedge clk) disable iff (rst)
    cpu_hit |-> cpu_p.idx == IDX_W'((cpu_addr - REGION_BASE) >> 1))
    else $error("cpu word index wrong");

  a_dma_index: assert property (@(posedge clk) disable iff (rst)
    dma_hit |-> dma_p.idx == IDX_W'((dma_addr - REGION_BASE) >> 1))
    else $error("dma word index wrong");

  a_out_zero: assert property (@(posedge clk) disable iff (rst)
    cpu_en && !cpu_we && !in_region(cpu_addr) |=> cpu_word == RD_RESET)
    else $error("outside read not zero");

  a_dma_out_zero: assert property (@(posedge clk) disable iff (rst)
    dma_en && !dma_we && !in_region(dma_addr) |=> dma_word == RD_RESET)
    else $error("dma outside read not zero");

  a_byte_read: assert property (@(posedge clk) disable iff (rst)
    cpu_hit && !cpu_we && cpu_byte |=> cpu_word[15:8] == 8'h00)
    else $error("byte read upper half not zero");

  a_dma_byte_read: assert property (@(posedge clk) disable iff (rst)
    dma_hit && !dma_we && dma_byte |=> dma_word[15:8] == 8'h00)
    else $error("dma byte read upper half not zero");
endmodule

/* testbench/dpr_dma_model.sv */
// Purpose: Behavioural DMA-side master for the dual-ported staging RAM.
// Assumes: Requests are driven just after a rising edge and held for one edge.
// Notes:   Idle address and data lines carry inverted junk so stale values are never reused.
module dpr_dma_model (
  input  wire logic        clk,
  output logic             en,
  output logic             we,
  output logic             bsel,
  output logic [15:0]      addr,
  output logic [15:0]      wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    en    = 1'b0;
    we    = 1'b0;
    bsel  = 1'b0;
    addr  = 16'h0000;
    wdata = 16'h0000;
  end
  // Writes stage incoming peripheral data, reads fetch outgoing data.
  task automatic req(input logic w, b, input logic [15:0] a, d);
    en    = 1'b1;
    we    = w;
    bsel  = b;
    addr  = a;
    wdata = d;
  endtask
  // Released address and data lines toggle so a design that samples them late is caught; bsel holds.
  task automatic idle();
    en    = 1'b0;
    we    = 1'b0;
    addr  = ~addr;
    wdata = ~wdata;
  endtask
endmodule

/* testbench/testbench.sv */
// Purpose: Self-checking bench for the dual-ported staging RAM.
// Assumes: Read data and rvalid appear just after the edge that takes the read.
// Notes:   Byte write data is mirrored on both halves; byte reads come back zero-extended.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dpr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cpu_en = 1'b0, cpu_we = 1'b0, cpu_byte = 1'b0;
  logic [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000;
  logic [15:0] cpu_rdata, dma_rdata, dma_addr, dma_wdata;
  logic        cpu_rvalid, dma_rvalid, dma_en, dma_we, dma_byte;
  int          miscompares = 0, num_checks = 0, cycles = 0;
  always #2.5 clk = ~clk;
  dpr_dma_model dma (.clk(clk), .en(dma_en), .we(dma_we), .bsel(dma_byte),
                     .addr(dma_addr), .wdata(dma_wdata));
  dpr_ram dpr_ram_inst (.clk(clk), .rst(rst), .cpu_en(cpu_en), .cpu_we(cpu_we),
    .cpu_byte(cpu_byte), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .dma_en(dma_en), .dma_we(dma_we),
    .dma_byte(dma_byte), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
    .dma_rdata(dma_rdata), .dma_rvalid(dma_rvalid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (miscompares == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request per port for a single edge, then both ports released.
  task automatic op(input logic ce, cw, cb, input logic [15:0] ca, cd,
                    input logic de, dw, db, input logic [15:0] da, dd);
    @(posedge clk);
    #1;
    cpu_en = ce;
    cpu_we = cw;
    cpu_byte = cb;
    cpu_addr = ca;
    cpu_wdata = cd;
    if (de) begin
      dma.req(dw, db, da, dd);
    end
    @(posedge clk);
    #1;
    cpu_en = 1'b0;
    cpu_we = 1'b0;
    cpu_addr = ~cpu_addr;
    cpu_wdata = ~cpu_wdata;
    dma.idle();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_plain();
    op(1, 1, 0, REGION_BASE, 16'ha55a, 0, 0, 0, 16'h0, 16'h0);
    check({15'h0, cpu_rvalid}, 16'h0000);
    op(1, 1, 0, 16'h7ffe, 16'h1234, 0, 0, 0, 16'h0, 16'h0);
    op(1, 0, 0, REGION_BASE, 16'h0, 0, 0, 0, 16'h0, 16'h0);
    check({15'h0, cpu_rvalid}, 16'h0001);
    check(cpu_rdata, 16'ha55a);
    op(1, 0, 0, 16'h7ffe, 16'h0, 0, 0, 0, 16'h0, 16'h0);
    check(cpu_rdata, 16'h1234);
    op(1, 1, 0, 16'h77fe, 16'h5555, 0, 0, 0, 16'h0, 16'h0);
    op(1, 0, 0, 16'h77fe, 16'h0, 0, 0, 0, 16'h0, 16'h0);
    check(cpu_rdata, 16'h0000);
  endtask
  task automatic t_dual();
    op(1, 1, 0, 16'h7810, 16'h1111, 1, 1, 0, 16'h7812, 16'h2222);
    op(1, 0, 0, 16'h7812, 16'h0, 1, 0, 0, 16'h7810, 16'h0);
    check({15'h0, cpu_rvalid}, 16'h0001);
    check({15'h0, dma_rvalid}, 16'h0001);
    check(cpu_rdata, 16'h2222);
    check(dma_rdata, 16'h1111);
    op(0, 0, 0, 16'h0, 16'h0, 1, 0, 0, 16'h8000, 16'h0);
    check(dma_rdata, 16'h0000);
  endtask
  task automatic t_clash();
    op(1, 1, 0, 16'h7820, 16'hbeef, 1, 1, 0, 16'h7820, 16'hdead);
    op(1, 0, 0, 16'h7820, 16'h0, 1, 0, 0, 16'h7820, 16'h0);
    check(cpu_rdata, 16'hbeef);
    check(dma_rdata, 16'hbeef);
    check({15'h0, dma_rvalid & cpu_rvalid}, 16'h0001);
  endtask
  task automatic t_byte();
    op(1, 1, 0, 16'h7830, 16'h1234, 0, 0, 0, 16'h0, 16'h0);
    op(1, 1, 1, 16'h7831, 16'habab, 0, 0, 0, 16'h0, 16'h0);
    op(1, 0, 0, 16'h7830, 16'h0, 0, 0, 0, 16'h0, 16'h0);
    check(cpu_rdata, 16'hab34);
    op(0, 0, 0, 16'h0, 16'h0, 1, 1, 1, 16'h7830, 16'hcdcd);
    op(1, 1, 0, 16'h0, 16'h0, 1, 0, 0, 16'h7830, 16'h0);
    check(dma_rdata, 16'habcd);
    op(1, 0, 1, 16'h7830, 16'h0, 1, 0, 1, 16'h7831, 16'h0);
    check(cpu_rdata, 16'h00cd);
    check(dma_rdata, 16'h00ab);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // The ceiling leaves ample margin over the few dozen cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    t_plain();
    t_dual();
    t_clash();
    t_byte();
    test_done();
  end
endmodule
